/* File: rtl/rls_core.sv */
// Registered logic sequencer: programmable arrays, J/K flops and I/O pins
// Operation
// - State flops change only on the rising clock edge.
// - Normal J/K: hold, clear on K, set on J, toggle on both.
// - Foldback inverter between J and K makes the flop D type.
// - Preset forces state high, reset forces low, ignoring J/K.
// - Preset and reset together give high; last released decides after.
// - Raised output enable floats registered pins; enable control is programmable.
// - Disabled outputs with load term set the complement of the load pin level into the flop.
// - Supervoltage on enable loads each flop from its pin, ignoring pattern.
// - After power-up all flops clear so registered pins read one.
// - Complement term is NOR of selected products, fed complemented back.
// - 32 product terms over inputs, pins, feedback; 21 sum terms.
// - Static line outputs pass a programmable polarity XOR.
// - Sum terms drive J, K, preset, reset; largest variant uses products. Here reset always comes from control term CT_RST.
// - Variants give 4, 6 or 8 registers with 8, 6 or 4 lines.
// - Registered pin carries complement of flop state.
// - D mode has K equal to not J; T mode K equals J.
// - Flop type term high gives J/K, low gives D; disabled means J/K.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rls_core
  import rls_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_reset,
  input  wire logic [AW-1:0]   i_addr,
  input  wire logic [DW-1:0]   i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [DW-1:0]   o_rdata,
  input  wire logic [NIN-1:0]  i_in,
  input  wire logic            i_oe_n,
  input  wire logic            i_oe_hv,
  input  wire logic [NPIN-1:0] i_pin,
  output logic      [NPIN-1:0] o_pin,
  output logic      [NPIN-1:0] o_pin_oe
);

  // ****************************
  // Pattern store
  // ****************************
  logic [NVAR-1:0]  and_t_q [NPT];
  logic [NVAR-1:0]  and_t_d [NPT];
  logic [NVAR-1:0]  and_c_q [NPT];
  logic [NVAR-1:0]  and_c_d [NPT];
  logic [NPT-1:0]   or_q    [NST];
  logic [NPT-1:0]   or_d    [NST];
  logic [NVAR-1:0]  ct_t_q  [NCT];
  logic [NVAR-1:0]  ct_t_d  [NCT];
  logic [NVAR-1:0]  ct_c_q  [NCT];
  logic [NVAR-1:0]  ct_c_d  [NCT];
  logic [NPT-1:0]   csel_q, csel_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [NPIN-1:0]  pol_q, pol_d;
  logic [NPIN-1:0]  dir_q, dir_d;
  logic [DW-1:0]    rdata_q, rdata_d;

  // ****************************
  // Pin synchronisers and array state
  // ****************************
  logic [NIN+NPIN+1:0] s1_q, s2_q;
  logic [NIN-1:0]      in_s;
  logic [NPIN-1:0]     pin_s;
  logic                oe_n_s, hv_s;
  logic [NFF-1:0]      q_q, q_d, act;
  logic [NPIN-1:0]     pin_q, pin_d, poe_q, poe_d;
  logic [NVAR-1:0]     v;
  logic [NPT-1:0]      pt_raw, pt;
  logic [NST-1:0]      sum;
  logic [NCT-1:0]      ct;
  logic                cterm, pre, rst, ftm, dis;
  logic [NFF-1:0]      set_v, clr_v, tog_v, hold_v, dm_v, ld_v, jv;

  assign {hv_s, oe_n_s, pin_s, in_s} = s2_q;
  assign o_rdata  = rdata_q;
  assign o_pin    = pin_q;
  assign o_pin_oe = poe_q;

  // ****************************
  // Register port
  // ****************************
  always_comb begin
    and_t_d = and_t_q;
    and_c_d = and_c_q;
    or_d    = or_q;
    ct_t_d  = ct_t_q;
    ct_c_d  = ct_c_q;
    csel_d  = csel_q;
    cfg_d   = cfg_q;
    pol_d   = pol_q;
    dir_d   = dir_q;
    rdata_d = '0;
    if (i_wr) begin
      for (int n = 0; n < NPT; n++) begin
        if (i_addr == A_AND_T + AW'(n)) and_t_d[n] = i_wdata[NVAR-1:0];
        if (i_addr == A_AND_C + AW'(n)) and_c_d[n] = i_wdata[NVAR-1:0];
      end
      for (int n = 0; n < NST; n++) begin
        if (i_addr == A_OR + AW'(n)) or_d[n] = i_wdata;
      end
      for (int n = 0; n < NCT; n++) begin
        if (i_addr == A_CT_T + AW'(n)) ct_t_d[n] = i_wdata[NVAR-1:0];
        if (i_addr == A_CT_C + AW'(n)) ct_c_d[n] = i_wdata[NVAR-1:0];
      end
      if (i_addr == A_CSEL) csel_d = i_wdata;
      if (i_addr == A_CFG) cfg_d = i_wdata[CFG_W-1:0];
      if (i_addr == A_POL) pol_d = i_wdata[NPIN-1:0];
      if (i_addr == A_DIR) dir_d = i_wdata[NPIN-1:0];
    end
    if (i_rd) begin
      // Unmapped words read as zero
      for (int n = 0; n < NPT; n++) begin
        if (i_addr == A_AND_T + AW'(n)) rdata_d = DW'(and_t_q[n]);
        if (i_addr == A_AND_C + AW'(n)) rdata_d = DW'(and_c_q[n]);
      end
      for (int n = 0; n < NST; n++) begin
        if (i_addr == A_OR + AW'(n)) rdata_d = or_q[n];
      end
      for (int n = 0; n < NCT; n++) begin
        if (i_addr == A_CT_T + AW'(n)) rdata_d = DW'(ct_t_q[n]);
        if (i_addr == A_CT_C + AW'(n)) rdata_d = DW'(ct_c_q[n]);
      end
      if (i_addr == A_CSEL) rdata_d = csel_q;
      if (i_addr == A_CFG) rdata_d = DW'(cfg_q);
      if (i_addr == A_POL) rdata_d = DW'(pol_q);
      if (i_addr == A_DIR) rdata_d = DW'(dir_q);
      if (i_addr == A_STAT) rdata_d = {10'h000, dis, hv_s, pin_s, q_q};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int n = 0; n < NPT; n++) begin
        and_t_q[n] <= '0;
        and_c_q[n] <= '0;
      end
      for (int n = 0; n < NST; n++) begin
        or_q[n] <= '0;
      end
      for (int n = 0; n < NCT; n++) begin
        ct_t_q[n] <= '0;
        ct_c_q[n] <= '0;
      end
      csel_q  <= '0;
      cfg_q   <= CFG_RST;
      pol_q   <= POL_RST;
      dir_q   <= DIR_RST;
      rdata_q <= '0;
    end else begin
      and_t_q <= and_t_d;
      and_c_q <= and_c_d;
      or_q    <= or_d;
      ct_t_q  <= ct_t_d;
      ct_c_q  <= ct_c_d;
      csel_q  <= csel_d;
      cfg_q   <= cfg_d;
      pol_q   <= pol_d;
      dir_q   <= dir_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************
  // Logic array and flop next state
  // ****************************
  always_comb begin
    int nr;
    int jx;
    logic j, k, ld;
    nr = 4;
    jx = 0;
    j  = 1'b0;
    k  = 1'b0;
    ld = 1'b0;
    unique case (rls_var_t'(cfg_q[CFG_VAR_LO +: 2]))
      VAR_R6:  nr = 6;
      VAR_R8:  nr = 8;
      default: nr = 4;
    endcase
    for (int i = 0; i < NFF; i++) begin
      act[i] = (i >= NFF - nr);
    end
    v = {1'b0, q_q, pin_s, in_s};
    // Complement term excluded from its own inputs to break the loop
    for (int n = 0; n < NPT; n++) begin
      pt_raw[n] = &((~and_t_q[n] | v) & (~and_c_q[n] | ~v));
    end
    cterm = ~|(pt_raw & csel_q);
    v[NVAR-1] = cterm;
    for (int n = 0; n < NPT; n++) begin
      pt[n] = &((~and_t_q[n] | v) & (~and_c_q[n] | ~v));
    end
    for (int n = 0; n < NST; n++) begin
      sum[n] = |(pt & or_q[n]);
    end
    // Blank masks leave a term true, so control terms must be programmed first
    for (int n = 0; n < NCT; n++) begin
      ct[n] = &((~ct_t_q[n] | v) & (~ct_c_q[n] | ~v));
    end
    // Preset and reset act at the next edge, not truly asynchronously
    pre = (nr == NFF) ? ct[CT_PRE] : sum[ST_PRE];
    rst = ct[CT_RST];
    ftm = cfg_q[CFG_FT_BIT] ? ct[CT_FT] : 1'b1;
    unique case (rls_oe_t'(cfg_q[CFG_OE_LO +: 2]))
      OE_ON:   dis = hv_s;
      OE_OFF:  dis = 1'b1;
      default: dis = hv_s | oe_n_s;
    endcase
    for (int i = 0; i < NFF; i++) begin
      jx = 2 * i + nr - 4;
      if (act[i]) begin
        j = sum[jx];
        k = sum[jx + 1];
      end else begin
        j = 1'b0;
        k = 1'b0;
      end
      if (!ftm) k = ~j;
      jv[i] = j;
      ld = dis & ((i < BANK_W) ? ct[CT_LDA] : ct[CT_LDB]);
      q_d[i] = q_q[i];
      if (!act[i]) q_d[i] = 1'b0;
      else if (hv_s) q_d[i] = ~pin_s[BANK_W + i];
      else if (pre) q_d[i] = 1'b1;
      else if (rst) q_d[i] = 1'b0;
      else if (ld) q_d[i] = ~pin_s[BANK_W + i];
      else q_d[i] = (j & ~q_q[i]) | (~k & q_q[i]);
      dm_v[i]   = act[i] & ~hv_s & ~pre & ~rst & ~ld & ~ftm;
      ld_v[i]   = act[i] & ~hv_s & ~pre & ~rst & ld;
      hold_v[i] = act[i] & ~hv_s & ~pre & ~rst & ~ld & ~j & ~k;
      set_v[i]  = act[i] & ~hv_s & ~pre & ~rst & ~ld & j & ~k;
      clr_v[i]  = act[i] & ~hv_s & ~pre & ~rst & ~ld & ~j & k;
      tog_v[i]  = act[i] & ~hv_s & ~pre & ~rst & ~ld & j & k;
    end
    for (int p = 0; p < NPIN; p++) begin
      if (p < NPIN - nr) begin
        pin_d[p] = sum[p] ^ pol_q[p];
        poe_d[p] = dir_q[p] & (~cfg_q[CFG_OC_BIT] | ~pin_d[p]);
      end else begin
        pin_d[p] = ~q_d[p - BANK_W];
        poe_d[p] = ~dis & (~cfg_q[CFG_OC_BIT] | ~pin_d[p]);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      q_q   <= '0;
      pin_q <= '1;
      poe_q <= '0;
    end else begin
      s1_q  <= {i_oe_hv, i_oe_n, i_pin, i_in};
      s2_q  <= s1_q;
      q_q   <= q_d;
      pin_q <= pin_d;
      poe_q <= poe_d;
    end
  end

  // ****************************
  // Checks
  // ****************************
  power_up_a: assert property (@(posedge i_clock)
    $fell(i_reset) |-> q_q == '0 && pin_q[11:4] == 8'hFF)
    else $error("flops not cleared after reset");
  pin_compl_a: assert property (@(posedge i_clock) disable iff (i_reset)
    ((pin_q[11:4] ^ ~q_q) & $past(act)) == '0)
    else $error("registered pin not complement of state");
  jk_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
    ((q_q ^ $past(q_q)) & $past(hold_v)) == '0)
    else $error("flop did not hold");
  jk_set_clr_a: assert property (@(posedge i_clock) disable iff (i_reset)
    |(set_v | clr_v) |=> (((q_q & $past(clr_v)) | (~q_q & $past(set_v))) == '0))
    else $error("flop set or clear wrong");
  jk_toggle_a: assert property (@(posedge i_clock) disable iff (i_reset)
    ((q_q ^ ~$past(q_q)) & $past(tog_v)) == '0)
    else $error("flop did not toggle");
  d_mode_a: assert property (@(posedge i_clock) disable iff (i_reset)
    |dm_v |=> ((q_q ^ $past(jv)) & $past(dm_v)) == '0)
    else $error("D mode did not follow J");
  preset_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (pre && !hv_s) |=> (q_q == $past(act)))
    else $error("preset did not force high");
  reset_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (rst && !pre && !hv_s) |=> q_q == '0)
    else $error("reset did not force low");
  out_off_a: assert property (@(posedge i_clock) disable iff (i_reset)
    dis |=> (poe_q[11:4] & $past(act)) == '0)
    else $error("registered pin driven while disabled");
  load_a: assert property (@(posedge i_clock) disable iff (i_reset)
    |ld_v |=> ((q_q ^ ~$past(pin_s[11:4])) & $past(ld_v)) == '0)
    else $error("load from pin failed");
  diag_a: assert property (@(posedge i_clock) disable iff (i_reset)
    hv_s |=> ((q_q ^ ~$past(pin_s[11:4])) & $past(act)) == '0)
    else $error("diagnostic load failed");
  inactive_zero_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (q_q & ~$past(act)) == '0)
    else $error("inactive flop not held low");
  oc_drive_a: assert property (@(posedge i_clock) disable iff (i_reset)
    $past(cfg_q[CFG_OC_BIT]) |-> (poe_q & pin_q) == '0)
    else $error("open collector pin driven high");
  static_dir_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (poe_q[3:0] & ~$past(dir_q[3:0])) == '0)
    else $error("static pin driven without direction");
  rdata_idle_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read cycle");

endmodule // rls_core
`default_nettype wire

/* File: rtl/rls_pkg.sv */
// Constants and types shared by the registered logic sequencer
package rls_pkg;

  // ****************************
  // Array dimensions
  // ****************************
  localparam int NPT  = 32;
  localparam int NST  = 21;
  localparam int NCT  = 10;
  localparam int NFF  = 8;
  localparam int NPIN = 12;
  localparam int NIN  = 4;
  localparam int NVAR = 25;
  localparam int AW   = 8;
  localparam int DW   = 32;

  // ****************************
  // Register word addresses
  // ****************************
  localparam logic [AW-1:0] A_AND_T = 8'h00;
  localparam logic [AW-1:0] A_AND_C = 8'h20;
  localparam logic [AW-1:0] A_OR    = 8'h40;
  localparam logic [AW-1:0] A_CSEL  = 8'h60;
  localparam logic [AW-1:0] A_CT_T  = 8'h70;
  localparam logic [AW-1:0] A_CT_C  = 8'h80;
  localparam logic [AW-1:0] A_CFG   = 8'h90;
  localparam logic [AW-1:0] A_POL   = 8'h91;
  localparam logic [AW-1:0] A_DIR   = 8'h92;
  localparam logic [AW-1:0] A_STAT  = 8'hA0;

  // ****************************
  // Configuration fields and reset values
  // ****************************
  localparam int CFG_W      = 6;
  localparam int CFG_VAR_LO = 0;
  localparam int CFG_OC_BIT = 2;
  localparam int CFG_OE_LO  = 3;
  localparam int CFG_FT_BIT = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [NPIN-1:0]  POL_RST = 12'h000;
  localparam logic [NPIN-1:0]  DIR_RST = 12'h000;

  // Control term and sum term roles
  localparam int CT_PRE = 0;
  localparam int CT_RST = 1;
  localparam int CT_FT  = 2;
  localparam int CT_LDA = 3;
  localparam int CT_LDB = 4;
  localparam int ST_PRE = 20;
  localparam int BANK_W = 4;

  typedef enum logic [1:0] {
    VAR_R4 = 2'h0,
    VAR_R6 = 2'h1,
    VAR_R8 = 2'h2
  } rls_var_t;

  typedef enum logic [1:0] {
    OE_EXT = 2'h0,
    OE_ON  = 2'h1,
    OE_OFF = 2'h2
  } rls_oe_t;

endpackage

/* File: test/rls_pin_model.sv */
// Far-side model: external logic sharing the registered and static pins
`timescale 1ns/1ps
`default_nettype none
module rls_pin_model
  import rls_pkg::*;
(
  input  wire logic [NPIN-1:0] i_pin_drv,
  input  wire logic [NPIN-1:0] i_pin_drv_oe,
  input  wire logic [NPIN-1:0] i_ext_val,
  input  wire logic [NPIN-1:0] i_ext_en,
  output logic      [NPIN-1:0] o_level
);
  // ****************************
  // Wire resolution
  // ****************************
  // Pull-up on every pin, so a floating pin reads one, never a stale value
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (i_pin_drv_oe[p]) begin
        o_level[p] = i_pin_drv[p];
      end else if (i_ext_en[p]) begin
        o_level[p] = i_ext_val[p];
      end else begin
        o_level[p] = 1'b1;
      end
    end
  end
endmodule // rls_pin_model
`default_nettype wire

/* File: test/rls_core_tb.sv */
// Self-checking bench for the registered logic sequencer core
`timescale 1ns/1ps
`default_nettype none
module rls_core_tb;
  import rls_pkg::*;
  logic            i_clock = 1'b0;
  logic            i_reset = 1'b1;
  logic [AW-1:0]   i_addr  = '0;
  logic [DW-1:0]   i_wdata = '0;
  logic            i_wr    = 1'b0;
  logic            i_rd    = 1'b0;
  logic [NIN-1:0]  i_in    = 4'h1;
  logic            i_oe_n  = 1'b0;
  logic            i_oe_hv = 1'b0;
  logic [NPIN-1:0] ext_val = 12'h000;
  logic [NPIN-1:0] ext_en  = 12'h000;
  logic [DW-1:0]   o_rdata;
  logic [NPIN-1:0] o_pin;
  logic [NPIN-1:0] o_pin_oe;
  logic [NPIN-1:0] pin_lvl;
  int              bad_count = 0;
  int              total_checks = 0;

  rls_core dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in(i_in), .i_oe_n(i_oe_n),
    .i_oe_hv(i_oe_hv), .i_pin(pin_lvl), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
  rls_pin_model far (.i_pin_drv(o_pin), .i_pin_drv_oe(o_pin_oe), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(pin_lvl));

  initial begin
    forever #4 i_clock = ~i_clock;
  end

  // ****************************
  // Shared tasks
  // ****************************
  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    check(o_rdata & m, e);
  endtask
  task automatic settle();
    repeat (6) @(posedge i_clock);
    #1;
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset();
    #1;
    check({20'h0, o_pin}, 32'hFFF);
    check({20'h0, o_pin_oe}, 32'h0);
    rd(A_STAT, 32'hFF, 32'h0);
    rd(8'hFF, 32'hFFFF_FFFF, 32'h0);
    wr(A_CFG, 32'h21);
    rd(A_CFG, 32'h3F, 32'h21);
    wr(A_CFG, 32'h0);
    // Blank masks make a term true; a term on in[0] and ~in[0] stays off
    for (int m = CT_RST; m <= CT_LDB; m++) begin
      wr(AW'(A_CT_T + m), 32'h1);
      wr(AW'(A_CT_C + m), 32'h1);
    end
    $display("test reset and registers done");
  endtask
  task automatic t_preset_jk();
    wr(A_AND_T, 32'h1);
    wr(AW'(A_OR + ST_PRE), 32'h1);
    settle();
    rd(A_STAT, 32'hFF, 32'hF0);
    check({20'h0, o_pin}, 32'h000);
    check({20'h0, o_pin_oe & 12'hF00}, 32'hF00);
    wr(AW'(A_OR + ST_PRE), 32'h0);
    wr(A_OR + 8'h09, 32'h1);
    settle();
    rd(A_STAT, 32'hFF, 32'hE0);
    wr(A_OR + 8'h09, 32'h0);
    wr(A_OR + 8'h08, 32'h1);
    settle();
    rd(A_STAT, 32'hFF, 32'hF0);
    wr(A_OR + 8'h08, 32'h0);
    // One-cycle pulse on in[1] drives J and K together for one edge
    wr(A_AND_T + 8'h01, 32'h2);
    wr(A_OR + 8'h08, 32'h2);
    wr(A_OR + 8'h09, 32'h2);
    @(posedge i_clock);
    i_in <= 4'h3;
    @(posedge i_clock);
    i_in <= 4'h1;
    settle();
    rd(A_STAT, 32'hFF, 32'hE0);
    wr(A_OR + 8'h08, 32'h0);
    wr(A_OR + 8'h09, 32'h0);
    wr(AW'(A_CT_C + CT_RST), 32'h0);
    settle();
    rd(A_STAT, 32'hFF, 32'h00);
    wr(AW'(A_OR + ST_PRE), 32'h1);
    settle();
    rd(A_STAT, 32'hFF, 32'hF0);
    wr(AW'(A_OR + ST_PRE), 32'h0);
    settle();
    rd(A_STAT, 32'hFF, 32'h00);
    wr(AW'(A_CT_C + CT_RST), 32'h1);
    $display("test preset and jk done");
  endtask
  task automatic t_dmode();
    wr(A_CFG, 32'h20);
    wr(A_OR + 8'h0A, 32'h1);
    settle();
    rd(A_STAT, 32'hFF, 32'h20);
    wr(A_OR + 8'h0A, 32'h0);
    settle();
    rd(A_STAT, 32'hFF, 32'h00);
    wr(A_CFG, 32'h0);
    $display("test d mode done");
  endtask
  task automatic t_load();
    i_oe_n <= 1'b1;
    settle();
    check({20'h0, o_pin_oe & 12'hF00}, 32'h0);
    @(posedge i_clock);
    ext_val <= 12'h300;
    ext_en <= 12'hF00;
    wr(AW'(A_CT_C + CT_LDB), 32'h0);
    settle();
    rd(A_STAT, 32'hFF, 32'hC0);
    wr(AW'(A_CT_C + CT_LDB), 32'h1);
    $display("test bank load done");
  endtask
  task automatic t_diag();
    @(posedge i_clock);
    i_oe_hv <= 1'b1;
    ext_val <= 12'hA00;
    settle();
    rd(A_STAT, 32'hFF, 32'h50);
    rd(A_STAT, 32'h0030_0000, 32'h0030_0000);
    @(posedge i_clock);
    i_oe_hv <= 1'b0;
    ext_en <= 12'h000;
    i_oe_n <= 1'b0;
    settle();
    check({20'h0, o_pin}, 32'hA00);
    $display("test diagnostic load done");
  endtask
  task automatic t_static();
    wr(A_POL, 32'h00F);
    wr(A_DIR, 32'h0FF);
    settle();
    check({20'h0, o_pin}, 32'hA0F);
    check({20'h0, o_pin_oe}, 32'hFFF);
    wr(A_CFG, 32'h04);
    settle();
    check({20'h0, o_pin_oe}, 32'h5F0);
    wr(A_CFG, 32'h0);
    $display("test static pins done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_preset_jk();
    t_dmode();
    t_load();
    t_diag();
    t_static();
    summarize();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
endmodule // rls_core_tb
`default_nettype wire
